/* logic/baseband_pkg.sv */
// Constants, register map and state encoding of the link-layer baseband
package baseband_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int CAL_TIME_US = 200;
  localparam int CAL_CYCLES = CAL_TIME_US * CYC_PER_US;
  localparam int ACK_STEP_US = 10;
  localparam int ACK_STEP_CYCLES = ACK_STEP_US * CYC_PER_US;

  localparam logic [6:0] ADDR_STATUS_A = 7'h00;
  localparam logic [6:0] ADDR_STATUS_B = 7'h01;
  localparam logic [6:0] ADDR_MASK_A = 7'h02;
  localparam logic [6:0] ADDR_MASK_B = 7'h03;
  localparam logic [6:0] ADDR_RADIO_CONTROL = 7'h04;
  localparam logic [6:0] ADDR_RADIO_SETUP = 7'h05;
  localparam logic [6:0] ADDR_CHANNEL = 7'h07;
  localparam logic [6:0] ADDR_STARTUP = 7'h08;
  localparam logic [6:0] ADDR_ACK_SETUP = 7'h0b;
  localparam logic [6:0] ADDR_RETRY_LIMIT = 7'h0c;
  localparam logic [6:0] ADDR_OWN0 = 7'h0e;
  localparam logic [6:0] ADDR_OWN1 = 7'h0f;
  localparam logic [6:0] ADDR_OWN2 = 7'h10;
  localparam logic [6:0] ADDR_PEER0 = 7'h11;
  localparam logic [6:0] ADDR_PEER1 = 7'h12;
  localparam logic [6:0] ADDR_PEER2 = 7'h13;
  localparam logic [6:0] ADDR_TX_LEN = 7'h14;
  localparam logic [6:0] ADDR_RX_LEN = 7'h15;
  localparam logic [6:0] ADDR_FIFO_CTRL = 7'h16;
  localparam logic [1:0] WIN_TX = 2'h2;
  localparam logic [1:0] WIN_RX = 2'h3;

  localparam int STA_RX_READY = 7;
  localparam int STA_TX_DONE = 6;
  localparam int STA_RETRY_LIMIT = 5;
  localparam int STB_CAL_DONE = 0;
  localparam int CTL_RUN = 1;
  localparam int CTL_DIR = 0;
  localparam int SETUP_CAL_REQ = 7;
  localparam int ACK_DISABLE = 4;
  localparam int FLAG_ACK = 5;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] FIFO_TX_ADVANCE = 8'h80;
  localparam logic [7:0] FIFO_RX_RELEASE = 8'h40;
  localparam logic [7:0] CHANNEL_MAX = 8'h27;
  localparam logic [7:0] PREAMBLE = 8'h55;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam int HDR_BITS = 40;
  localparam int FLAGS_START = 32;
  localparam int FLAGS_BITS = 8;
  localparam int CRC_BITS = 16;
  localparam int BUF_DEPTH = 2;

  typedef enum logic [2:0] {ST_IDLE, ST_CAL, ST_START, ST_TX, ST_ACK_WAIT, ST_RX} engine_state_t;
endpackage

/* logic/radio_baseband.sv */
// Link-layer baseband: SPI register slave, calibration, packet framer and deframer
// Function
// - Calibration request self-clears after calibration finishes
// - Calibration-done flag on calibration end or PLL set-up
// - Channel writes above 39 become 39
// - FIFO control 0x80 marks the transmit buffer loaded
// - Run plus direction set starts a transmission
// - Send one burst, then listen for acknowledgement
// - Transmit-done raised after valid acknowledgement, or at burst end when acknowledgement is disabled
// - NACK or timeout retries until limit, then standby
// - Receive-ready only when address and CRC valid
// - Auto-acknowledge a good packet, then keep receiving
// - Payload to 0x60-0x7F, length to 0x15
// - Clearing run bit ends reception
// - Preamble 01010101, complemented when address LSB set
// - Three-byte address, must match own address
// - Flags: 2-bit id, ack bit, 5-bit length
// - Data payload 1..32 bytes; acknowledgement has none
// - CRC-16 x16+x12+x5+1 generated and checked
// - Least significant byte and bit first
// - Acknowledgement with bad CRC counts as NACK
// - Packet id plus CRC suppress duplicate reports
// - Status bits clear on write one only
// - Interrupt high when any unmasked status bit set
`timescale 1ns/1ps
module radio_baseband
  import baseband_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_sck_i,
  input wire logic spi_sdi_i,
  output logic spi_sdo_o,
  output logic spi_sdo_oe_o,
  output logic irq_o,
  output logic tx_bit_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  input wire logic rx_bit_i,
  input wire logic rx_valid_i,
  output logic radio_on_o,
  output logic radio_tx_o,
  output logic [5:0] channel_o,
  output logic [2:0] power_level_o,
  output logic pll_cal_busy_o
);

  typedef struct packed {
    engine_state_t st;
    logic [1:0] csn_s;
    logic [1:0] sck_s;
    logic [1:0] sdi_s;
    logic csn_prev;
    logic sck_prev;
    logic [2:0] spi_bits;
    logic [7:0] spi_in;
    logic [7:0] spi_out;
    logic spi_first;
    logic spi_wr;
    logic [6:0] spi_addr;
    logic sdo;
    logic sdo_oe;
    logic [7:0] sta_a;
    logic [7:0] sta_b;
    logic [7:0] msk_a;
    logic [7:0] msk_b;
    logic [7:0] ctl;
    logic [7:0] setup;
    logic [7:0] chan;
    logic [7:0] startup;
    logic [7:0] ack_setup;
    logic [7:0] retry_lim;
    logic [7:0] tx_len;
    logic [7:0] rx_len;
    logic [23:0] own;
    logic [23:0] peer;
    logic [31:0][7:0] tx_mem;
    logic [31:0][7:0] rx_mem;
    logic tx_loaded;
    logic rx_full;
    logic [15:0] cnt;
    logic [8:0] bitcnt;
    logic [15:0] crc;
    logic [15:0] rcrc;
    logic [31:0] sr;
    logic in_frame;
    logic send_ack;
    logic [1:0] packet_sequence_id;
    logic [1:0] ack_pid;
    logic [7:0] retries;
    logic [7:0] rflags;
    logic [7:0] rbyte;
    logic seen;
    logic [1:0] last_pid;
    logic [15:0] last_crc;
    logic [BUF_DEPTH-1:0] buf_data;
    logic [1:0] buf_cnt;
  } state_t;

  state_t q_r;
  state_t q_nxt;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    logic fb;
    fb = b ^ c[15];
    crc_step = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
  endfunction

  function automatic logic [7:0] preamble_for(input logic addr_lsb);
    preamble_for = addr_lsb ? ~PREAMBLE : PREAMBLE;
  endfunction

  always_comb
  begin
    logic sck_rise;
    logic sck_fall;
    logic csn_act;
    logic csn_fall;
    logic [7:0] b;
    logic [6:0] ra;
    logic [7:0] rd;
    logic we;
    logic [7:0] txf;
    logic [8:0] pbits;
    logic [8:0] total;
    logic [7:0] fb_byte;
    logic [5:0] bidx;
    logic [8:0] crc_ofs;
    logic [8:0] rpbits;
    logic [31:0] sr_n;
    logic [15:0] rcrc_n;
    logic [7:0] rbyte_n;
    logic crc_ok;
    logic frame_end;
    logic do_retry;
    logic push;
    logic push_bit;
    logic dup;
    logic [1:0] c;
    logic [BUF_DEPTH-1:0] d;
    q_nxt = q_r;
    sck_rise = q_r.sck_s[1] & ~q_r.sck_prev;
    sck_fall = ~q_r.sck_s[1] & q_r.sck_prev;
    csn_act = ~q_r.csn_s[1];
    csn_fall = csn_act & q_r.csn_prev;
    b = {q_r.spi_in[6:0], q_r.sdi_s[1]};
    ra = q_r.spi_first ? b[6:0] : q_r.spi_addr;
    we = 1'b0;
    push = 1'b0;
    push_bit = 1'b0;
    do_retry = 1'b0;
    frame_end = 1'b0;
    crc_ok = 1'b0;
    dup = 1'b0;
    rd = RESET_BYTE;
    fb_byte = 8'h00;
    sr_n = {rx_bit_i, q_r.sr[31:1]};
    rcrc_n = {rx_bit_i, q_r.rcrc[15:1]};
    rbyte_n = {rx_bit_i, q_r.rbyte[7:1]};
    txf = q_r.send_ack ? {q_r.ack_pid, 1'b1, 5'd0} : {q_r.packet_sequence_id, 1'b0, q_r.tx_len[4:0]};
    pbits = q_r.send_ack ? 9'd0 : {1'b0, q_r.tx_len[4:0], 3'b000} + 9'd8;
    total = 9'(HDR_BITS) + pbits + 9'(CRC_BITS);
    crc_ofs = q_r.bitcnt - 9'(HDR_BITS) - pbits;
    rpbits = q_r.rflags[FLAG_ACK] ? 9'd0 : {4'd0, q_r.rflags[4:0]} * 9'd8 + 9'd8;
    bidx = q_r.bitcnt[8:3];
    case (bidx)
      6'd0: fb_byte = preamble_for(q_r.peer[0]);
      6'd1: fb_byte = q_r.peer[7:0];
      6'd2: fb_byte = q_r.peer[15:8];
      6'd3: fb_byte = q_r.peer[23:16];
      6'd4: fb_byte = txf;
      default: fb_byte = q_r.tx_mem[5'(bidx - 6'd5)];
    endcase

    // Synchronisers: only the second stage is read by any logic
    q_nxt.csn_s = {q_r.csn_s[0], spi_cs_n_i};
    q_nxt.sck_s = {q_r.sck_s[0], spi_sck_i};
    q_nxt.sdi_s = {q_r.sdi_s[0], spi_sdi_i};
    q_nxt.csn_prev = q_r.csn_s[1];
    q_nxt.sck_prev = q_r.sck_s[1];

    case (ra)
      ADDR_STATUS_A: rd = q_r.sta_a;
      ADDR_STATUS_B: rd = q_r.sta_b;
      ADDR_MASK_A: rd = q_r.msk_a;
      ADDR_MASK_B: rd = q_r.msk_b;
      ADDR_RADIO_CONTROL: rd = q_r.ctl;
      ADDR_RADIO_SETUP: rd = q_r.setup;
      ADDR_CHANNEL: rd = q_r.chan;
      ADDR_STARTUP: rd = q_r.startup;
      ADDR_ACK_SETUP: rd = q_r.ack_setup;
      ADDR_RETRY_LIMIT: rd = q_r.retry_lim;
      ADDR_OWN0: rd = q_r.own[7:0];
      ADDR_OWN1: rd = q_r.own[15:8];
      ADDR_OWN2: rd = q_r.own[23:16];
      ADDR_PEER0: rd = q_r.peer[7:0];
      ADDR_PEER1: rd = q_r.peer[15:8];
      ADDR_PEER2: rd = q_r.peer[23:16];
      ADDR_TX_LEN: rd = q_r.tx_len;
      ADDR_RX_LEN: rd = q_r.rx_len;
      default: rd = (ra[6:5] == WIN_RX) ? q_r.rx_mem[ra[4:0]] : RESET_BYTE;
    endcase

    // SPI slave: bytes in MSB first on rising SCK, out on falling SCK
    if (!csn_act)
    begin
      q_nxt.spi_bits = 3'd0;
      q_nxt.spi_first = 1'b1;
      q_nxt.sdo_oe = 1'b0;
    end
    else
    begin
      q_nxt.sdo_oe = 1'b1;
      if (csn_fall)
      begin
        q_nxt.sdo = q_r.sta_a[7];
        q_nxt.spi_out = {q_r.sta_a[6:0], 1'b0};
      end
      else if (sck_fall)
      begin
        q_nxt.sdo = q_r.spi_out[7];
        q_nxt.spi_out = {q_r.spi_out[6:0], 1'b0};
      end
      if (sck_rise)
      begin
        q_nxt.spi_in = b;
        q_nxt.spi_bits = q_r.spi_bits + 3'd1;
        if (q_r.spi_bits == 3'd7)
        begin
          q_nxt.spi_first = 1'b0;
          if (q_r.spi_first)
            q_nxt.spi_wr = b[7];
          we = ~q_r.spi_first & q_r.spi_wr;
          if (q_r.spi_first ? ~b[7] : ~q_r.spi_wr)
            q_nxt.spi_out = rd;
          // A write's first data byte lands on the address itself, a read prefetches ahead
          q_nxt.spi_addr = (q_r.spi_first && b[7]) ? ra : ra + 7'd1;
        end
      end
    end

    if (we)
    begin
      case (q_r.spi_addr)
        ADDR_STATUS_A: q_nxt.sta_a = q_r.sta_a & ~b;
        ADDR_STATUS_B: q_nxt.sta_b = q_r.sta_b & ~b;
        ADDR_MASK_A: q_nxt.msk_a = b;
        ADDR_MASK_B: q_nxt.msk_b = b;
        ADDR_RADIO_CONTROL: q_nxt.ctl = b;
        ADDR_RADIO_SETUP: q_nxt.setup = b;
        ADDR_CHANNEL: q_nxt.chan = (b > CHANNEL_MAX) ? CHANNEL_MAX : b;
        ADDR_STARTUP: q_nxt.startup = b;
        ADDR_ACK_SETUP: q_nxt.ack_setup = b;
        ADDR_RETRY_LIMIT: q_nxt.retry_lim = b;
        ADDR_OWN0: q_nxt.own[7:0] = b;
        ADDR_OWN1: q_nxt.own[15:8] = b;
        ADDR_OWN2: q_nxt.own[23:16] = b;
        ADDR_PEER0: q_nxt.peer[7:0] = b;
        ADDR_PEER1: q_nxt.peer[15:8] = b;
        ADDR_PEER2: q_nxt.peer[23:16] = b;
        ADDR_TX_LEN: q_nxt.tx_len = b;
        ADDR_FIFO_CTRL:
        begin
          if (b == FIFO_TX_ADVANCE)
            q_nxt.tx_loaded = 1'b1;
          if (b == FIFO_RX_RELEASE)
            q_nxt.rx_full = 1'b0;
        end
        default:
        begin
          if (q_r.spi_addr[6:5] == WIN_TX)
            q_nxt.tx_mem[q_r.spi_addr[4:0]] = b;
        end
      endcase
    end

    // Engine runs after the register writes so that hardware sets win over clears
    case (q_r.st)
      ST_IDLE:
      begin
        q_nxt.cnt = 16'd0;
        if (q_r.setup[SETUP_CAL_REQ])
          q_nxt.st = ST_CAL;
        else if (q_r.ctl[CTL_RUN])
        begin
          q_nxt.st = ST_START;
          q_nxt.retries = 8'd0;
        end
      end
      ST_CAL:
      begin
        q_nxt.cnt = q_r.cnt + 16'd1;
        if (q_r.cnt == 16'(CAL_CYCLES - 1))
        begin
          q_nxt.setup[SETUP_CAL_REQ] = 1'b0;
          q_nxt.sta_b[STB_CAL_DONE] = 1'b1;
          q_nxt.st = ST_IDLE;
        end
      end
      ST_START:
      begin
        q_nxt.cnt = q_r.cnt + 16'd1;
        if (!q_r.ctl[CTL_RUN])
          q_nxt.st = ST_IDLE;
        else if (q_r.cnt >= 16'(q_r.startup) * 16'(CYC_PER_US))
        begin
          q_nxt.sta_b[STB_CAL_DONE] = 1'b1;
          q_nxt.bitcnt = 9'd0;
          q_nxt.crc = CRC_INIT;
          q_nxt.send_ack = 1'b0;
          q_nxt.in_frame = 1'b0;
          q_nxt.sr = 32'd0;
          q_nxt.st = q_r.ctl[CTL_DIR] ? ST_TX : ST_RX;
        end
      end
      ST_TX:
      begin
        if (q_r.buf_cnt != 2'(BUF_DEPTH))
        begin
          push = 1'b1;
          q_nxt.bitcnt = q_r.bitcnt + 9'd1;
          if (q_r.bitcnt < 9'(HDR_BITS) + pbits)
          begin
            push_bit = fb_byte[q_r.bitcnt[2:0]];
            if (q_r.bitcnt >= 9'(FLAGS_START))
              q_nxt.crc = crc_step(q_r.crc, push_bit);
          end
          else
            push_bit = q_r.crc[crc_ofs[3:0]];
          if (q_r.bitcnt == total - 9'd1)
          begin
            q_nxt.in_frame = 1'b0;
            q_nxt.sr = 32'd0;
            q_nxt.cnt = 16'd0;
            if (q_r.send_ack)
              q_nxt.st = ST_RX;
            else if (!q_r.ack_setup[ACK_DISABLE])
              q_nxt.st = ST_ACK_WAIT;
            else
            begin
              q_nxt.sta_a[STA_TX_DONE] = 1'b1;
              q_nxt.ctl[CTL_RUN] = 1'b0;
              q_nxt.tx_loaded = 1'b0;
              q_nxt.packet_sequence_id = q_r.packet_sequence_id + 2'd1;
              q_nxt.st = ST_IDLE;
            end
          end
        end
      end
      ST_ACK_WAIT, ST_RX:
      begin
        if (!q_r.ctl[CTL_RUN])
          q_nxt.st = ST_IDLE;
        if (q_r.st == ST_ACK_WAIT && !q_r.in_frame)
        begin
          q_nxt.cnt = q_r.cnt + 16'd1;
          if (q_r.cnt >= 16'(q_r.ack_setup[3:0] + 5'd1) * 16'(ACK_STEP_CYCLES))
            do_retry = 1'b1;
        end
        if (rx_valid_i && !q_r.in_frame)
        begin
          q_nxt.sr = sr_n;
          if (sr_n == {q_r.own, preamble_for(q_r.own[0])})
          begin
            q_nxt.in_frame = 1'b1;
            q_nxt.bitcnt = 9'd0;
            q_nxt.crc = CRC_INIT;
          end
        end
        else if (rx_valid_i)
        begin
          q_nxt.bitcnt = q_r.bitcnt + 9'd1;
          q_nxt.rbyte = rbyte_n;
          if (q_r.bitcnt == 9'(FLAGS_BITS - 1))
            q_nxt.rflags = rbyte_n;
          if (q_r.bitcnt < 9'(FLAGS_BITS) + rpbits || q_r.bitcnt < 9'(FLAGS_BITS))
          begin
            q_nxt.crc = crc_step(q_r.crc, rx_bit_i);
            if (q_r.bitcnt >= 9'(FLAGS_BITS) && q_r.bitcnt[2:0] == 3'd7 && !q_r.rx_full
                && q_r.st == ST_RX)
              q_nxt.rx_mem[5'(q_r.bitcnt[8:3] - 6'd1)] = rbyte_n;
          end
          else
          begin
            q_nxt.rcrc = rcrc_n;
            if (q_r.bitcnt == 9'(FLAGS_BITS + CRC_BITS - 1) + rpbits)
            begin
              frame_end = 1'b1;
              crc_ok = (rcrc_n == q_r.crc);
              q_nxt.in_frame = 1'b0;
              q_nxt.sr = 32'd0;
            end
          end
        end
        if (frame_end && q_r.st == ST_ACK_WAIT && q_r.rflags[FLAG_ACK])
        begin
          if (crc_ok)
          begin
            q_nxt.sta_a[STA_TX_DONE] = 1'b1;
            q_nxt.ctl[CTL_RUN] = 1'b0;
            q_nxt.tx_loaded = 1'b0;
            q_nxt.packet_sequence_id = q_r.packet_sequence_id + 2'd1;
            q_nxt.st = ST_IDLE;
          end
          else
            do_retry = 1'b1;
        end
        // A full receive window drops the packet unacknowledged so the sender retries
        if (frame_end && q_r.st == ST_RX && !q_r.rflags[FLAG_ACK] && crc_ok && !q_r.rx_full)
        begin
          dup = q_r.seen && q_r.last_pid == q_r.rflags[7:6] && q_r.last_crc == q_r.crc;
          if (!dup)
          begin
            q_nxt.rx_full = 1'b1;
            q_nxt.rx_len = 8'(q_r.rflags[4:0]) + 8'd1;
            q_nxt.sta_a[STA_RX_READY] = 1'b1;
          end
          q_nxt.seen = 1'b1;
          q_nxt.last_pid = q_r.rflags[7:6];
          q_nxt.last_crc = q_r.crc;
          if (!q_r.ack_setup[ACK_DISABLE] && q_r.ctl[CTL_RUN])
          begin
            q_nxt.ack_pid = q_r.rflags[7:6];
            q_nxt.send_ack = 1'b1;
            q_nxt.bitcnt = 9'd0;
            q_nxt.crc = CRC_INIT;
            q_nxt.st = ST_TX;
          end
        end
        if (do_retry && q_r.ctl[CTL_RUN])
        begin
          q_nxt.in_frame = 1'b0;
          q_nxt.sr = 32'd0;
          if (q_r.retries == q_r.retry_lim)
          begin
            q_nxt.sta_a[STA_RETRY_LIMIT] = 1'b1;
            q_nxt.ctl[CTL_RUN] = 1'b0;
            q_nxt.st = ST_IDLE;
          end
          else
          begin
            q_nxt.retries = q_r.retries + 8'd1;
            q_nxt.bitcnt = 9'd0;
            q_nxt.crc = CRC_INIT;
            q_nxt.send_ack = 1'b0;
            q_nxt.st = ST_TX;
          end
        end
      end
      default: q_nxt.st = ST_IDLE;
    endcase

    // Two-entry bit buffer toward the modulator; head is entry 0
    c = q_r.buf_cnt;
    d = q_r.buf_data;
    if (c != 2'd0 && tx_ready_i)
    begin
      d = {1'b0, d[BUF_DEPTH-1:1]};
      c = c - 2'd1;
    end
    if (push)
    begin
      d[c[0]] = push_bit;
      c = c + 2'd1;
    end
    q_nxt.buf_data = d;
    q_nxt.buf_cnt = c;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q_r <= '0;
      q_r.csn_s <= 2'b11;
      q_r.csn_prev <= 1'b1;
    end
    else
      q_r <= q_nxt;
  end

  assign spi_sdo_o = q_r.sdo;
  assign spi_sdo_oe_o = q_r.sdo_oe;
  assign irq_o = |(q_r.sta_a & q_r.msk_a) | |(q_r.sta_b & q_r.msk_b);
  assign tx_bit_o = q_r.buf_data[0];
  assign tx_valid_o = q_r.buf_cnt != 2'd0;
  assign radio_on_o = q_r.st == ST_START || q_r.st == ST_TX || q_r.st == ST_ACK_WAIT
    || q_r.st == ST_RX;
  assign radio_tx_o = q_r.st == ST_TX;
  assign channel_o = q_r.chan[5:0];
  assign power_level_o = q_r.setup[2:0];
  assign pll_cal_busy_o = q_r.st == ST_CAL;

endmodule

/* test/radio_link_props.sv */
// Port-level assertions for the radio baseband
`timescale 1ns/1ps
module radio_link_props
  import baseband_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_sck_i,
  input wire logic spi_sdi_i,
  input wire logic spi_sdo_o,
  input wire logic spi_sdo_oe_o,
  input wire logic irq_o,
  input wire logic tx_bit_o,
  input wire logic tx_valid_o,
  input wire logic tx_ready_i,
  input wire logic rx_bit_i,
  input wire logic rx_valid_i,
  input wire logic radio_on_o,
  input wire logic radio_tx_o,
  input wire logic [5:0] channel_o,
  input wire logic [2:0] power_level_o,
  input wire logic pll_cal_busy_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Counts busy cycles; cleared whenever calibration is idle
  logic [11:0] busy_cnt_r;
  logic [11:0] busy_cnt_nxt;
  always_comb busy_cnt_nxt = pll_cal_busy_o ? busy_cnt_r + 12'h001 : 12'h000;
  always_ff @(posedge clk_i) busy_cnt_r <= rst_i ? 12'h000 : busy_cnt_nxt;
  sequence cs_idle_s;
    spi_cs_n_i [*5];
  endsequence
  sequence cs_active_s;
    !spi_cs_n_i [*5];
  endsequence
  oe_off_a: assert property (cs_idle_s |-> !spi_sdo_oe_o)
    else $error("sdo enable while deselected");
  oe_on_a: assert property (cs_active_s |-> spi_sdo_oe_o)
    else $error("sdo enable missing while selected");
  // Sync delay keeps the falling-edge update well inside the low phase
  sdo_steady_a: assert property (spi_sck_i [*3] |=> $stable(spi_sdo_o))
    else $error("sdo moved while clock high");
  chan_range_a: assert property (channel_o <= 6'h27)
    else $error("channel above 39");
  tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_bit_o))
    else $error("air bit dropped during stall");
  tx_on_a: assert property (radio_tx_o |-> radio_on_o)
    else $error("serialising with radio off");
  valid_src_a: assert property ($rose(tx_valid_o) |-> $past(radio_tx_o))
    else $error("air valid without framer");
  cal_length_a: assert property ($fell(pll_cal_busy_o) |->
    busy_cnt_r >= CAL_CYCLES - 2 && busy_cnt_r <= CAL_CYCLES + 2)
    else $error("calibration length wrong");
  reset_quiet_a: assert property (disable iff (1'b0) rst_i |=>
    !irq_o && !tx_valid_o && !spi_sdo_oe_o)
    else $error("outputs active after reset");
endmodule
bind radio_baseband radio_link_props radio_link_props_i (.clk_i, .rst_i, .spi_cs_n_i,
  .spi_sck_i, .spi_sdi_i, .spi_sdo_o, .spi_sdo_oe_o, .irq_o, .tx_bit_o, .tx_valid_o,
  .tx_ready_i, .rx_bit_i, .rx_valid_i, .radio_on_o, .radio_tx_o, .channel_o,
  .power_level_o, .pll_cal_busy_o);

/* test/spi_host_model.sv */
// Host controller model: mode 0 serial master, 800 ns clock period
`timescale 1ns/1ps
module spi_host_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [2:0] nb_i,
  input wire logic [31:0] wd_i,
  input wire logic sdo_i,
  output logic cs_n_o,
  output logic sck_o,
  output logic sdi_o,
  output logic done_o,
  output logic [31:0] rd_o
);
  logic [31:0] sh;
  initial
  begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    sdi_o = 1'b0;
    done_o = 1'b0;
    rd_o = 32'h0;
    forever
    begin
      @(posedge clk_i);
      done_o <= 1'b0;
      if (go_i)
      begin
        sh = wd_i;
        cs_n_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        // Whole bytes only, most significant bit first
        repeat (nb_i * 8)
        begin
          sdi_o <= sh[31];
          sh = sh << 1;
          repeat (4) @(posedge clk_i);
          sck_o <= 1'b1;
          rd_o <= {rd_o[30:0], sdo_i};
          repeat (4) @(posedge clk_i);
          sck_o <= 1'b0;
        end
        repeat (4) @(posedge clk_i);
        cs_n_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        done_o <= 1'b1;
      end
    end
  end
endmodule

/* test/radio_link_layer_baseband_bench.sv */
// Self-checking bench: registers, calibration, air transmit and receive
`timescale 1ns/1ps
module radio_link_layer_baseband_bench
  import baseband_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic tx_ready_i = 1'b0;
  logic rx_bit_i = 1'b0;
  logic rx_valid_i = 1'b0;
  logic go = 1'b0;
  logic [2:0] nb = 3'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rnd = 32'h6d97;
  logic cs_n, sck, sdi, sdo_w, done, spi_sdo_o, spi_sdo_oe_o, irq_o, tx_bit_o, tx_valid_o;
  logic radio_on_o, radio_tx_o, pll_cal_busy_o;
  logic [31:0] rd;
  logic [5:0] channel_o;
  logic [2:0] power_level_o;
  logic [7:0] chans [5] = '{8'h00, 8'h28, 8'hff, 8'h27, 8'h13};
  int failures = 0;
  int check_count = 0;
  initial forever #50 clk_i = ~clk_i;
  // No pull on the data-out wire: a released line shows the inverse of its last bit
  assign sdo_w = spi_sdo_oe_o ? spi_sdo_o : ~spi_sdo_o;
  radio_baseband radio_baseband_i (.clk_i, .rst_i, .spi_cs_n_i(cs_n), .spi_sck_i(sck),
    .spi_sdi_i(sdi), .spi_sdo_o, .spi_sdo_oe_o, .irq_o, .tx_bit_o, .tx_valid_o, .tx_ready_i,
    .rx_bit_i, .rx_valid_i, .radio_on_o, .radio_tx_o, .channel_o, .power_level_o,
    .pll_cal_busy_o);
  spi_host_model spi_host_model_i (.clk_i, .go_i(go), .nb_i(nb), .wd_i(wd), .sdo_i(sdo_w),
    .cs_n_o(cs_n), .sck_o(sck), .sdi_o(sdi), .done_o(done), .rd_o(rd));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction
  function automatic logic [7:0] clamp(input logic [7:0] v);
    return (v > CHANNEL_MAX) ? CHANNEL_MAX : v;
  endfunction
  function automatic logic [79:0] mkframe(input logic [23:0] a, input logic [7:0] fl,
    input logic [23:0] pl);
    logic [79:0] f;
    logic [15:0] c;
    f = {16'h0, pl, fl, a, a[0] ? ~PREAMBLE : PREAMBLE};
    c = CRC_INIT;
    for (int i = 32; i < 64; i++)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ f[i]) ? CRC_POLY : 16'h0);
    f[79:64] = c;
    return f;
  endfunction
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [79:0] e, input logic [79:0] g);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic spi(input logic [2:0] n, input logic [31:0] w);
    int k;
    @(posedge clk_i);
    go <= 1'b1;
    nb <= n;
    wd <= w;
    @(posedge clk_i);
    go <= 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 400)
    begin
      @(posedge clk_i);
      k++;
    end
    chk("spi done", 1'b1, done);
    if (done !== 1'b1)
      results();
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    spi(3'd2, {1'b1, a, d, 16'h0});
  endtask
  task automatic reg_is(input string n, input logic [6:0] a, input logic [7:0] e);
    spi(3'd2, {1'b0, a, 24'h0});
    chk(n, e, rd[7:0]);
  endtask
  task automatic wait_irq(input int lim);
    int k;
    k = 0;
    while (irq_o !== 1'b1 && k < lim)
    begin
      @(posedge clk_i);
      k++;
    end
    chk("irq wait", 1'b1, irq_o);
    if (irq_o !== 1'b1)
      results();
  endtask
  task automatic send(input logic [79:0] f);
    for (int i = 0; i < 80; i++)
    begin
      @(posedge clk_i);
      rx_bit_i <= f[i];
      rx_valid_i <= 1'b1;
      @(posedge clk_i);
      rx_valid_i <= 1'b0;
      rx_bit_i <= ~f[i];
    end
  endtask
  initial
  begin
    logic [23:0] own, peer, pl;
    logic [79:0] f, e;
    int n;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    reg_is("channel reset", ADDR_CHANNEL, 8'h00);
    reg_is("status reset", ADDR_STATUS_A, 8'h00);
    $display("test reset done");
    rnd = lfsr(rnd);
    chans[0] = rnd[7:0];
    foreach (chans[i])
    begin
      wr(ADDR_CHANNEL, chans[i]);
      reg_is("channel", ADDR_CHANNEL, clamp(chans[i]));
      chk("channel pin", clamp(chans[i]), channel_o);
    end
    $display("test channel done");
    wr(ADDR_MASK_B, 8'h01);
    wr(ADDR_RADIO_SETUP, 8'h80);
    wait_irq(3000);
    reg_is("cal request", ADDR_RADIO_SETUP, 8'h00);
    reg_is("cal done", ADDR_STATUS_B, 8'h01);
    wr(ADDR_MASK_B, 8'h00);
    chk("irq masked", 1'b0, irq_o);
    wr(ADDR_STATUS_B, 8'h00);
    reg_is("status keep", ADDR_STATUS_B, 8'h01);
    wr(ADDR_STATUS_B, 8'h01);
    reg_is("status clear", ADDR_STATUS_B, 8'h00);
    $display("test calibration done");
    rnd = lfsr(rnd);
    peer = {rnd[23:4], 4'hf};
    rnd = lfsr(rnd);
    pl = rnd[23:0];
    spi(3'd4, {1'b1, ADDR_PEER0, peer[7:0], peer[15:8], peer[23:16]});
    wr(ADDR_ACK_SETUP, 8'h10);
    wr(ADDR_TX_LEN, 8'h02);
    spi(3'd4, {1'b1, WIN_TX, 5'h00, pl[7:0], pl[15:8], pl[23:16]});
    wr(ADDR_FIFO_CTRL, FIFO_TX_ADVANCE);
    spi(3'd3, {1'b1, ADDR_STATUS_A, 16'hffff, 8'h00});
    spi(3'd3, {1'b1, ADDR_MASK_A, 8'h40, 8'h00, 8'h00});
    wr(ADDR_RADIO_CONTROL, 8'h03);
    n = 0;
    for (int k = 0; k < 4000 && n < 80; k++)
    begin
      @(posedge clk_i);
      if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1)
      begin
        f[n] = tx_bit_o;
        n++;
      end
      rnd = lfsr(rnd);
      tx_ready_i <= rnd[3];
    end
    tx_ready_i <= 1'b1;
    e = mkframe(peer, 8'h02, pl);
    chk("tx frame", e, f);
    wait_irq(4000);
    reg_is("tx done", ADDR_STATUS_A, 8'h40);
    reg_is("pll setup", ADDR_STATUS_B, 8'h01);
    $display("test transmit done");
    wr(ADDR_ACK_SETUP, 8'h00);
    wr(ADDR_RETRY_LIMIT, 8'h01);
    spi(3'd3, {1'b1, ADDR_STATUS_A, 16'hffff, 8'h00});
    wr(ADDR_MASK_A, 8'h20);
    wr(ADDR_RADIO_CONTROL, 8'h03);
    wait_irq(2000);
    reg_is("retry limit", ADDR_STATUS_A, 8'h20);
    reg_is("run cleared", ADDR_RADIO_CONTROL, 8'h01);
    $display("test retry done");
    rnd = lfsr(rnd);
    own = {rnd[23:4], 4'hf};
    rnd = lfsr(rnd);
    pl = rnd[23:0];
    spi(3'd4, {1'b1, ADDR_OWN0, own[7:0], own[15:8], own[23:16]});
    spi(3'd3, {1'b1, ADDR_STATUS_A, 16'hffff, 8'h00});
    wr(ADDR_MASK_A, 8'h80);
    wr(ADDR_RADIO_CONTROL, 8'h02);
    for (int k = 0; k < 50 && radio_on_o !== 1'b1; k++)
      @(posedge clk_i);
    chk("radio on", 1'b1, radio_on_o);
    e = mkframe(own, 8'h42, pl);
    f = e;
    f[70] = ~f[70];
    send(f);
    send(mkframe(own ^ 24'h000100, 8'h42, pl));
    repeat (10) @(posedge clk_i);
    chk("irq bad frames", 1'b0, irq_o);
    send(e);
    wait_irq(200);
    chk("ack start", 1'b1, radio_tx_o);
    reg_is("rx length", ADDR_RX_LEN, 8'h03);
    spi(3'd4, {1'b0, WIN_RX, 5'h00, 24'h0});
    chk("rx payload", {pl[7:0], pl[15:8], pl[23:16]}, rd[23:0]);
    wr(ADDR_FIFO_CTRL, FIFO_RX_RELEASE);
    wr(ADDR_STATUS_A, 8'h80);
    send(e);
    repeat (10) @(posedge clk_i);
    chk("irq duplicate", 1'b0, irq_o);
    wr(ADDR_RADIO_CONTROL, 8'h00);
    chk("radio off", 1'b0, radio_on_o);
    $display("test receive done");
    results();
  end
endmodule
